// *** rtl/cmp_ctrl_pkg.sv ***
// Package: register map, field layout and types of the comparator control block
package cmp_ctrl_pkg;
    // APB byte addresses
    localparam logic [11:0] ADDR_MODE = 12'h09D;
    localparam logic [11:0] ADDR_MODE_BYTE = 12'h274;
    localparam logic [11:0] ADDR_INSEL = 12'h000;
    localparam logic [11:0] ADDR_CTRL = 12'h004;
    localparam logic [11:0] ADDR_STATUS = 12'h008;
    localparam logic [11:0] ADDR_IRQ_STAT = 12'h00C;
    localparam logic [11:0] ADDR_IRQ_EN = 12'h010;
    localparam logic [11:0] ADDR_IRQ_CLR = 12'h014;
    // Mode control register
    localparam logic [7:0] MODE_RESET = 8'h02;
    localparam logic [7:0] MODE_WMASK = 8'h33;
    localparam int MODE_RISE_BIT = 5;
    localparam int MODE_FALL_BIT = 4;
    // Input select fields
    localparam logic [7:0] INSEL_RESET = 8'h00;
    localparam int INSEL_POS_LSB = 4;
    localparam int INSEL_NEG_LSB = 0;
    // Control register bits
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_OD_LATCHED_BIT = 1;
    localparam int CTRL_OD_RAW_BIT = 2;
    localparam int CTRL_RST_EN_BIT = 3;
    localparam int CTRL_WAKE_EN_BIT = 4;
    localparam int CTRL_ROUTE_LATCHED_BIT = 5;
    localparam int CTRL_ROUTE_RAW_BIT = 6;
    // Interrupt status layout
    localparam int IRQ_RISE_BIT = 0;
    localparam int IRQ_FALL_BIT = 1;
    localparam logic [1:0] IRQ_RESET = 2'h0;

    typedef struct packed {
        logic [3:0] pos_sel;
        logic [3:0] neg_sel;
    } input_sel_s;

    typedef struct packed {
        logic data_out;
        logic out_en;
    } pin_drive_s;
endpackage

// *** rtl/comparator_output_control.sv ***
// Comparator output control: APB registers, latched/raw outputs, edge events
//
// Behaviour
// RULE1 - Two comparator results go to pins, one latched on sys_clk and one raw and asynchronous.
// RULE2 - The raw result is combinational from the comparator so it tracks with no clock running.
// RULE3 - With the comparator disabled both routed pin outputs are driven low.
// RULE4 - Software can poll the result, and it feeds an interrupt and an oscillator wake request.
// RULE5 - Software can enable the result as a device reset source.
// RULE6 - The input select register holds a four-bit positive and a four-bit negative field.
// RULE7 - Software sets comparator input pins to analog and skipped by the crossbar.
// RULE8 - Each routed output pin is configurable as open-drain or push-pull.
// RULE9 - Rise and fall flags set on latched result edges, interrupting only when enabled.
`timescale 1ns/1ps
`default_nettype none

module comparator_output_control (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cmp_analog_out,
    output logic cmp_enable,
    output logic [3:0] positive_input_field,
    output logic [3:0] negative_input_field,
    output logic [1:0] response_select,
    output logic latched_compare_out,
    output logic latched_pin_o,
    output logic latched_pin_oe,
    output logic raw_compare_out,
    output logic raw_pin_o,
    output logic raw_pin_oe,
    output logic irq,
    output logic wake_req,
    output logic reset_req
);
    logic [7:0] mode_q;
    cmp_ctrl_pkg::input_sel_s insel_q;
    logic [7:0] ctrl_q;
    logic [1:0] irq_stat_q;
    logic [1:0] irq_en_q;
    logic sync1_q;
    logic sync2_q;
    logic prev_q;
    logic bus_wr;
    logic bus_rd;
    logic addr_ok;
    logic [1:0] edge_ev;
    logic [1:0] clr_req;
    logic raw_val;
    cmp_ctrl_pkg::pin_drive_s raw_drv;

    function automatic logic hit(input logic [11:0] a);
        hit = (a == cmp_ctrl_pkg::ADDR_MODE_BYTE) || (a == cmp_ctrl_pkg::ADDR_INSEL)
            || (a == cmp_ctrl_pkg::ADDR_CTRL) || (a == cmp_ctrl_pkg::ADDR_STATUS)
            || (a == cmp_ctrl_pkg::ADDR_IRQ_STAT) || (a == cmp_ctrl_pkg::ADDR_IRQ_EN)
            || (a == cmp_ctrl_pkg::ADDR_IRQ_CLR);
    endfunction

    // Pin drive: open-drain drives only low
    function automatic cmp_ctrl_pkg::pin_drive_s drive(input logic val, input logic od, input logic route);
        drive.data_out = val;
        drive.out_en = route && (!od || !val);
    endfunction

    assign addr_ok = hit(paddr);
    assign bus_wr = psel && penable && pwrite && addr_ok;
    assign bus_rd = psel && !penable && !pwrite;

    // APB: one-cycle access phase, error on unmapped address
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            prdata <= 32'h0000_0000;
        end else if (bus_rd) begin
            case (paddr)
                cmp_ctrl_pkg::ADDR_MODE_BYTE: prdata <= {24'h000000, mode_q};
                cmp_ctrl_pkg::ADDR_INSEL: prdata <= {24'h000000, insel_q}; // see RULE6
                cmp_ctrl_pkg::ADDR_CTRL: prdata <= {24'h000000, ctrl_q};
                cmp_ctrl_pkg::ADDR_STATUS: prdata <= {31'h0000_0000, sync2_q}; // see RULE4
                cmp_ctrl_pkg::ADDR_IRQ_STAT: prdata <= {30'h0000_0000, irq_stat_q};
                cmp_ctrl_pkg::ADDR_IRQ_EN: prdata <= {30'h0000_0000, irq_en_q};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Configuration registers
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            mode_q <= cmp_ctrl_pkg::MODE_RESET;
            insel_q <= cmp_ctrl_pkg::INSEL_RESET;
            ctrl_q <= cmp_ctrl_pkg::CTRL_RESET;
            irq_en_q <= cmp_ctrl_pkg::IRQ_RESET;
        end else if (bus_wr && pready) begin
            case (paddr)
                cmp_ctrl_pkg::ADDR_MODE_BYTE: mode_q <= pwdata[7:0] & cmp_ctrl_pkg::MODE_WMASK;
                cmp_ctrl_pkg::ADDR_INSEL: insel_q <= pwdata[7:0]; // see RULE6
                cmp_ctrl_pkg::ADDR_CTRL: ctrl_q <= {1'b0, pwdata[6:0]};
                cmp_ctrl_pkg::ADDR_IRQ_EN: irq_en_q <= pwdata[1:0];
                default: ;
            endcase
        end
    end

    // Comparator result synchroniser
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            sync1_q <= cmp_analog_out;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    // Edge events, gated by per-edge enables in mode register
    assign edge_ev[cmp_ctrl_pkg::IRQ_RISE_BIT] = ctrl_q[cmp_ctrl_pkg::CTRL_EN_BIT] && sync2_q && !prev_q
        && mode_q[cmp_ctrl_pkg::MODE_RISE_BIT]; // see RULE9
    assign edge_ev[cmp_ctrl_pkg::IRQ_FALL_BIT] = ctrl_q[cmp_ctrl_pkg::CTRL_EN_BIT] && !sync2_q && prev_q
        && mode_q[cmp_ctrl_pkg::MODE_FALL_BIT]; // see RULE9
    assign clr_req = (bus_wr && pready && paddr == cmp_ctrl_pkg::ADDR_IRQ_CLR) ? pwdata[1:0] : 2'h0;

    // Sticky flags, set wins over clear
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            irq_stat_q <= cmp_ctrl_pkg::IRQ_RESET;
        end else begin
            irq_stat_q <= (irq_stat_q & ~clr_req) | edge_ev; // see RULE9
        end
    end

    // Registered outputs
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            irq <= 1'b0;
            wake_req <= 1'b0;
            reset_req <= 1'b0;
            latched_compare_out <= 1'b0;
            latched_pin_o <= 1'b0;
            latched_pin_oe <= 1'b0;
            cmp_enable <= 1'b0;
            positive_input_field <= 4'h0;
            negative_input_field <= 4'h0;
            response_select <= cmp_ctrl_pkg::MODE_RESET[1:0];
        end else begin
            irq <= |(irq_stat_q & irq_en_q); // see RULE4
            wake_req <= ctrl_q[cmp_ctrl_pkg::CTRL_WAKE_EN_BIT] && ctrl_q[cmp_ctrl_pkg::CTRL_EN_BIT]
                && sync2_q; // see RULE4
            reset_req <= ctrl_q[cmp_ctrl_pkg::CTRL_RST_EN_BIT] && ctrl_q[cmp_ctrl_pkg::CTRL_EN_BIT]
                && !sync2_q; // see RULE5
            latched_compare_out <= ctrl_q[cmp_ctrl_pkg::CTRL_EN_BIT] && sync2_q; // see RULE1
            {latched_pin_o, latched_pin_oe} <= drive(ctrl_q[cmp_ctrl_pkg::CTRL_EN_BIT] && sync2_q,
                ctrl_q[cmp_ctrl_pkg::CTRL_OD_LATCHED_BIT],
                ctrl_q[cmp_ctrl_pkg::CTRL_ROUTE_LATCHED_BIT]); // see RULE3 see RULE8
            cmp_enable <= ctrl_q[cmp_ctrl_pkg::CTRL_EN_BIT];
            positive_input_field <= insel_q.pos_sel; // see RULE6
            negative_input_field <= insel_q.neg_sel;
            response_select <= mode_q[1:0];
        end
    end

    // Raw path: no flip-flop so it works with the clock stopped
    assign raw_val = ctrl_q[cmp_ctrl_pkg::CTRL_EN_BIT] && cmp_analog_out; // see RULE2 see RULE3
    assign raw_drv = drive(raw_val, ctrl_q[cmp_ctrl_pkg::CTRL_OD_RAW_BIT],
        ctrl_q[cmp_ctrl_pkg::CTRL_ROUTE_RAW_BIT]); // see RULE8
    assign raw_compare_out = raw_val; // see RULE1
    assign raw_pin_o = raw_drv.data_out;
    assign raw_pin_oe = raw_drv.out_en;

    a_disabled_low: assert property (@(posedge sys_clk) disable iff (!resetn)
        !ctrl_q[cmp_ctrl_pkg::CTRL_EN_BIT] |=> !latched_pin_o && !latched_compare_out) // see RULE3
        else $error("latched output not low while disabled");
    a_raw_disabled: assert property (@(posedge sys_clk) disable iff (!resetn)
        !ctrl_q[cmp_ctrl_pkg::CTRL_EN_BIT] |-> !raw_pin_o) // see RULE3
        else $error("raw output not low while disabled");
    a_latched_delay: assert property (@(posedge sys_clk) disable iff (!resetn)
        cmp_enable && $past(ctrl_q[cmp_ctrl_pkg::CTRL_EN_BIT], 1) |-> latched_compare_out == $past(sync2_q, 1)
        ) // see RULE1
        else $error("latched output does not follow synchronised result");
    a_raw_tracks: assert property (@(posedge sys_clk) disable iff (!resetn)
        raw_compare_out == (ctrl_q[cmp_ctrl_pkg::CTRL_EN_BIT] && cmp_analog_out)) // see RULE2
        else $error("raw output not tracking comparator");
    a_rise_flag: assert property (@(posedge sys_clk) disable iff (!resetn)
        $rose(sync2_q) && ctrl_q[cmp_ctrl_pkg::CTRL_EN_BIT] && mode_q[cmp_ctrl_pkg::MODE_RISE_BIT]
        |=> irq_stat_q[cmp_ctrl_pkg::IRQ_RISE_BIT]) // see RULE9
        else $error("rise flag not set");
    a_fall_gated: assert property (@(posedge sys_clk) disable iff (!resetn)
        $fell(sync2_q) && !mode_q[cmp_ctrl_pkg::MODE_FALL_BIT] && !irq_stat_q[cmp_ctrl_pkg::IRQ_FALL_BIT]
        |=> !irq_stat_q[cmp_ctrl_pkg::IRQ_FALL_BIT]) // see RULE9
        else $error("fall flag set while disabled");
    a_irq_level: assert property (@(posedge sys_clk) disable iff (!resetn)
        |(irq_stat_q & irq_en_q) |=> irq) // see RULE4
        else $error("interrupt not raised");
    a_reset_src: assert property (@(posedge sys_clk) disable iff (!resetn)
        reset_req |-> $past(ctrl_q[cmp_ctrl_pkg::CTRL_RST_EN_BIT], 1)) // see RULE5
        else $error("reset request without enable");
    a_od_never_high: assert property (@(posedge sys_clk) disable iff (!resetn)
        ctrl_q[cmp_ctrl_pkg::CTRL_OD_RAW_BIT] |-> !(raw_pin_oe && raw_pin_o)) // see RULE8
        else $error("open-drain pin driven high");
    a_insel_field: assert property (@(posedge sys_clk) disable iff (!resetn)
        bus_wr && pready && paddr == cmp_ctrl_pkg::ADDR_INSEL
        |=> ##1 positive_input_field == $past(pwdata[7:4], 2)) // see RULE6
        else $error("positive field not applied");

    // Bus timing checks
    a_pready_pulse: assert property (@(posedge sys_clk) disable iff (!resetn)
        pready |=> !pready)
        else $error("pready longer than one cycle");

    a_pready_setup: assert property (@(posedge sys_clk) disable iff (!resetn)
        psel && !penable |=> pready)
        else $error("pready missing after setup");

    a_pready_idle: assert property (@(posedge sys_clk) disable iff (!resetn)
        !psel |=> !pready)
        else $error("pready without select");

    a_slverr_ready: assert property (@(posedge sys_clk) disable iff (!resetn)
        pslverr |-> pready)
        else $error("pslverr without pready");

    a_slverr_addr: assert property (@(posedge sys_clk) disable iff (!resetn)
        psel && !penable && !addr_ok |=> pslverr)
        else $error("unmapped address not refused");

    a_no_slverr_ok: assert property (@(posedge sys_clk) disable iff (!resetn)
        psel && !penable && addr_ok |=> !pslverr)
        else $error("mapped address refused");

    a_prdata_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
        !bus_rd |=> $stable(prdata))
        else $error("read data changed without read");

    a_status_read: assert property (@(posedge sys_clk) disable iff (!resetn)
        bus_rd && paddr == cmp_ctrl_pkg::ADDR_STATUS |=> prdata == {31'h0000_0000, $past(sync2_q)}) // see RULE4
        else $error("status read wrong");

    // Register content checks
    a_mode_mask: assert property (@(posedge sys_clk) disable iff (!resetn)
        (mode_q & ~cmp_ctrl_pkg::MODE_WMASK) == 8'h00)
        else $error("mode reserved bits set");

    a_mode_reserved: assert property (@(posedge sys_clk) disable iff (!resetn)
        mode_q[7:6] == 2'h0)
        else $error("mode top bits set");

    a_ctrl_top: assert property (@(posedge sys_clk) disable iff (!resetn)
        !ctrl_q[7])
        else $error("control top bit set");

    a_enable_copy: assert property (@(posedge sys_clk) disable iff (!resetn)
        cmp_enable == $past(ctrl_q[cmp_ctrl_pkg::CTRL_EN_BIT]))
        else $error("enable copy wrong");

    a_resp_copy: assert property (@(posedge sys_clk) disable iff (!resetn)
        response_select == $past(mode_q[1:0]))
        else $error("response select copy wrong");

    a_pos_copy: assert property (@(posedge sys_clk) disable iff (!resetn)
        positive_input_field == $past(insel_q.pos_sel)) // see RULE6
        else $error("positive field copy wrong");

    a_neg_field: assert property (@(posedge sys_clk) disable iff (!resetn)
        bus_wr && pready && paddr == cmp_ctrl_pkg::ADDR_INSEL
        |=> ##1 negative_input_field == $past(pwdata[3:0], 2)) // see RULE6
        else $error("negative field not applied");

    // Result path checks
    a_sync_chain: assert property (@(posedge sys_clk) disable iff (!resetn)
        sync2_q == $past(sync1_q))
        else $error("synchroniser chain broken");

    a_raw_pin_val: assert property (@(posedge sys_clk) disable iff (!resetn)
        raw_pin_o == raw_compare_out) // see RULE1
        else $error("raw pin value wrong");

    a_latched_pin_val: assert property (@(posedge sys_clk) disable iff (!resetn)
        latched_pin_o == latched_compare_out) // see RULE1
        else $error("latched pin value wrong");

    a_raw_route: assert property (@(posedge sys_clk) disable iff (!resetn)
        !ctrl_q[cmp_ctrl_pkg::CTRL_ROUTE_RAW_BIT] |-> !raw_pin_oe) // see RULE8
        else $error("raw pin driven while not routed");

    a_latched_route: assert property (@(posedge sys_clk) disable iff (!resetn)
        !ctrl_q[cmp_ctrl_pkg::CTRL_ROUTE_LATCHED_BIT] |=> !latched_pin_oe) // see RULE8
        else $error("latched pin driven while not routed");

    a_raw_oe_pp: assert property (@(posedge sys_clk) disable iff (!resetn)
        ctrl_q[cmp_ctrl_pkg::CTRL_ROUTE_RAW_BIT] && !ctrl_q[cmp_ctrl_pkg::CTRL_OD_RAW_BIT] |-> raw_pin_oe) // see RULE8
        else $error("push-pull raw pin not driven");

    a_od_latched: assert property (@(posedge sys_clk) disable iff (!resetn)
        $past(ctrl_q[cmp_ctrl_pkg::CTRL_OD_LATCHED_BIT]) |-> !(latched_pin_oe && latched_pin_o)) // see RULE8
        else $error("open-drain latched pin driven high");

    a_wake_src: assert property (@(posedge sys_clk) disable iff (!resetn)
        wake_req |-> $past(ctrl_q[cmp_ctrl_pkg::CTRL_WAKE_EN_BIT]) && $past(sync2_q)) // see RULE4
        else $error("wake request without cause");

    a_reset_level: assert property (@(posedge sys_clk) disable iff (!resetn)
        reset_req |-> !$past(sync2_q)) // see RULE5
        else $error("reset request while result high");

    // Flag and interrupt checks
    a_irq_gated: assert property (@(posedge sys_clk) disable iff (!resetn)
        irq |-> $past(|(irq_stat_q & irq_en_q))) // see RULE9
        else $error("interrupt without enabled flag");

    a_clear_flag: assert property (@(posedge sys_clk) disable iff (!resetn)
        clr_req[cmp_ctrl_pkg::IRQ_RISE_BIT] && !edge_ev[cmp_ctrl_pkg::IRQ_RISE_BIT]
        |=> !irq_stat_q[cmp_ctrl_pkg::IRQ_RISE_BIT]) // see RULE9
        else $error("rise flag not cleared");

    a_flag_sticky: assert property (@(posedge sys_clk) disable iff (!resetn)
        irq_stat_q[cmp_ctrl_pkg::IRQ_FALL_BIT] && !clr_req[cmp_ctrl_pkg::IRQ_FALL_BIT]
        |=> irq_stat_q[cmp_ctrl_pkg::IRQ_FALL_BIT]) // see RULE9
        else $error("fall flag lost");

    a_rise_needs_en: assert property (@(posedge sys_clk) disable iff (!resetn)
        $rose(irq_stat_q[cmp_ctrl_pkg::IRQ_RISE_BIT])
        |-> $past(mode_q[cmp_ctrl_pkg::MODE_RISE_BIT]) && $past(ctrl_q[cmp_ctrl_pkg::CTRL_EN_BIT])) // see RULE9
        else $error("rise flag set while disabled");

    a_fall_needs_en: assert property (@(posedge sys_clk) disable iff (!resetn)
        $rose(irq_stat_q[cmp_ctrl_pkg::IRQ_FALL_BIT]) |-> $past(mode_q[cmp_ctrl_pkg::MODE_FALL_BIT])) // see RULE9
        else $error("fall flag set without enable");

    // Open-drain release seen on a routed pin
    c_od_release: cover property (@(posedge sys_clk) disable iff (!resetn)
        ctrl_q[cmp_ctrl_pkg::CTRL_OD_RAW_BIT] && ctrl_q[cmp_ctrl_pkg::CTRL_ROUTE_RAW_BIT] && !raw_pin_oe);

    c_rise_irq: cover property (@(posedge sys_clk) disable iff (!resetn) $rose(irq));
    c_fall_flag: cover property (@(posedge sys_clk) disable iff (!resetn)
        $rose(irq_stat_q[cmp_ctrl_pkg::IRQ_FALL_BIT]));
    c_reset_req: cover property (@(posedge sys_clk) disable iff (!resetn) $rose(reset_req));
    c_wake: cover property (@(posedge sys_clk) disable iff (!resetn) $rose(wake_req));
endmodule

`default_nettype wire

// *** verif/cmp_core_model.sv ***
// Behavioural analog comparator core and pull-up pin pads behind the crossbar
`timescale 1ns/1ps
`default_nettype none

module cmp_core_model (
    input wire logic cmp_enable,
    input wire logic [3:0] pos_sel,
    input wire logic [3:0] neg_sel,
    input wire logic [15:0][7:0] vin,
    output logic cmp_out,
    input wire logic [1:0] pin_o,
    input wire logic [1:0] pin_oe,
    output logic [1:0] pin
);
    // Disabled core floats high so the block's own gating is exercised
    assign cmp_out = cmp_enable ? (vin[pos_sel] > vin[neg_sel]) : 1'b1;
    // Released pads read high through the pull-up
    assign pin[0] = pin_oe[0] ? pin_o[0] : 1'b1;
    assign pin[1] = pin_oe[1] ? pin_o[1] : 1'b1;
endmodule

`default_nettype wire

// *** verif/comparator_output_control_bench.sv ***
// Self-checking bench of the comparator output control block
`timescale 1ns/1ps
`default_nettype none

module comparator_output_control_bench;
    logic sys_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, clk_run = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd_q;
    logic pready, pslverr, cmp_analog_out, cmp_enable, err_q, e;
    logic [3:0] pos_f, neg_f, p, n;
    logic [1:0] response_select, pin;
    logic latched_compare_out, latched_pin_o, latched_pin_oe, raw_compare_out, raw_pin_o, raw_pin_oe;
    logic irq, wake_req, reset_req;
    logic [15:0][7:0] vin = '0;
    integer seed = 81, miscompares = 0, checks = 0, i;

    comparator_output_control comparator_output_control_inst (.sys_clk(sys_clk), .resetn(resetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cmp_analog_out(cmp_analog_out), .cmp_enable(cmp_enable),
        .positive_input_field(pos_f), .negative_input_field(neg_f), .response_select(response_select),
        .latched_compare_out(latched_compare_out), .latched_pin_o(latched_pin_o),
        .latched_pin_oe(latched_pin_oe), .raw_compare_out(raw_compare_out), .raw_pin_o(raw_pin_o),
        .raw_pin_oe(raw_pin_oe), .irq(irq), .wake_req(wake_req), .reset_req(reset_req));

    cmp_core_model cmp_core_model_inst (.cmp_enable(cmp_enable), .pos_sel(pos_f), .neg_sel(neg_f),
        .vin(vin), .cmp_out(cmp_analog_out), .pin_o({raw_pin_o, latched_pin_o}),
        .pin_oe({raw_pin_oe, latched_pin_oe}), .pin(pin));

    initial forever begin
        #4;
        if (clk_run) sys_clk = ~sys_clk;
    end

    function automatic logic exp_cmp(input logic [15:0][7:0] v, input logic [3:0] a, input logic [3:0] b);
        return v[a] > v[b];
    endfunction

    task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        checks = checks + 1;
        if (g !== x) begin
            miscompares = miscompares + 1;
            $display("ERROR %s expected %h seen %h", nm, x, g);
        end
    endtask

    task chkb(input string nm, input logic x, input logic g);
        chk(nm, {31'h0, x}, {31'h0, g});
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk("prdata", x, rd_q);
    endtask

    // Positive input 1 against negative input 0
    task setres(input logic v);
        vin[1] <= v ? 8'hC0 : 8'h10;
        vin[0] <= 8'h80;
        repeat (5) @(posedge sys_clk);
    endtask

    task test_done;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        #100000;
        miscompares = miscompares + 1;
        test_done;
    end

    initial begin
        repeat (5) @(posedge sys_clk);
        resetn <= 1'b1;
        rd(cmp_ctrl_pkg::ADDR_MODE_BYTE, 32'h02);
        rd(cmp_ctrl_pkg::ADDR_INSEL, 32'h0);
        rd(cmp_ctrl_pkg::ADDR_CTRL, 32'h0);
        rd(cmp_ctrl_pkg::ADDR_IRQ_EN, 32'h0);
        chk("response_select", 32'h2, {30'h0, response_select});
        apb(1'b0, 12'h0FC, 32'h0);
        chkb("pslverr", 1'b1, err_q);
        chk("prdata", 32'h0, rd_q);
        apb(1'b1, cmp_ctrl_pkg::ADDR_MODE_BYTE, 32'hFFFFFFFF);
        rd(cmp_ctrl_pkg::ADDR_MODE_BYTE, 32'h33);
        chk("response_select", 32'h3, {30'h0, response_select});
        for (i = 0; i < 8; i++) begin
            p = $random(seed);
            n = $random(seed);
            vin <= {$random(seed), $random(seed), $random(seed), $random(seed)};
            apb(1'b1, cmp_ctrl_pkg::ADDR_INSEL, {24'h0, p, n});
            apb(1'b1, cmp_ctrl_pkg::ADDR_CTRL, 32'h01);
            rd(cmp_ctrl_pkg::ADDR_INSEL, {24'h0, p, n});
            chk("fields", {24'h0, p, n}, {24'h0, pos_f, neg_f});
            repeat (5) @(posedge sys_clk);
            e = exp_cmp(vin, p, n);
            chkb("latched", e, latched_compare_out);
            chkb("raw", e, raw_compare_out);
            rd(cmp_ctrl_pkg::ADDR_STATUS, {31'h0, e});
        end
        apb(1'b1, cmp_ctrl_pkg::ADDR_INSEL, 32'h10);
        apb(1'b1, cmp_ctrl_pkg::ADDR_CTRL, 32'h60);
        setres(1'b1);
        chkb("raw", 1'b0, raw_compare_out);
        chk("pins", 32'h0, {30'h0, pin});
        apb(1'b1, cmp_ctrl_pkg::ADDR_CTRL, 32'h61);
        setres(1'b1);
        chk("pins", 32'h3, {30'h0, pin});
        #1 clk_run = 1'b0;
        #20 vin[1] = 8'h10;
        #20 chkb("raw", 1'b0, raw_compare_out);
        chkb("raw pin", 1'b0, pin[1]);
        vin[1] = 8'hC0;
        #20 chkb("raw pin", 1'b1, pin[1]);
        clk_run = 1'b1;
        apb(1'b1, cmp_ctrl_pkg::ADDR_CTRL, 32'h67);
        setres(1'b1);
        chk("oe pins", 32'h3, {28'h0, latched_pin_oe, raw_pin_oe, pin});
        setres(1'b0);
        chk("oe pins", 32'hC, {28'h0, latched_pin_oe, raw_pin_oe, pin});
        apb(1'b1, cmp_ctrl_pkg::ADDR_CTRL, 32'h61);
        setres(1'b1);
        chk("oe pins", 32'hF, {28'h0, latched_pin_oe, raw_pin_oe, pin});
        apb(1'b1, cmp_ctrl_pkg::ADDR_MODE_BYTE, 32'h32);
        apb(1'b1, cmp_ctrl_pkg::ADDR_IRQ_EN, 32'h1);
        setres(1'b0);
        apb(1'b1, cmp_ctrl_pkg::ADDR_IRQ_CLR, 32'h3);
        rd(cmp_ctrl_pkg::ADDR_IRQ_STAT, 32'h0);
        setres(1'b1);
        rd(cmp_ctrl_pkg::ADDR_IRQ_STAT, 32'h1);
        chkb("irq", 1'b1, irq);
        setres(1'b0);
        rd(cmp_ctrl_pkg::ADDR_IRQ_STAT, 32'h3);
        apb(1'b1, cmp_ctrl_pkg::ADDR_IRQ_CLR, 32'h1);
        rd(cmp_ctrl_pkg::ADDR_IRQ_STAT, 32'h2);
        chkb("irq", 1'b0, irq);
        apb(1'b1, cmp_ctrl_pkg::ADDR_IRQ_CLR, 32'h2);
        apb(1'b1, cmp_ctrl_pkg::ADDR_MODE_BYTE, 32'h12);
        setres(1'b1);
        rd(cmp_ctrl_pkg::ADDR_IRQ_STAT, 32'h0);
        setres(1'b0);
        rd(cmp_ctrl_pkg::ADDR_IRQ_STAT, 32'h2);
        apb(1'b1, cmp_ctrl_pkg::ADDR_CTRL, 32'h19);
        setres(1'b1);
        chk("wake reset", 32'h2, {30'h0, wake_req, reset_req});
        setres(1'b0);
        chk("wake reset", 32'h1, {30'h0, wake_req, reset_req});
        test_done;
    end
endmodule

`default_nettype wire
